// File: common/srcr_pkg.sv
// Package of constants and types for the start/reset command block
package srcr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] SRCR_ADDR_CMD = 16'h0003;
  localparam logic [15:0] SRCR_PTR_RESET = 16'h0000;
  localparam logic [15:0] SRCR_RSVD_MASK = 16'hf100;
  // ----------------------------------------------------------------
  // Command bit positions
  // ----------------------------------------------------------------
  localparam int SRCR_B_SOFT_REINIT = 0;
  localparam int SRCR_B_LAUNCH = 1;
  localparam int SRCR_B_IRQ_CLEAR = 2;
  localparam int SRCR_B_TT_ZERO = 3;
  localparam int SRCR_B_TT_STEP = 4;
  localparam int SRCR_B_HALT_FRAME = 5;
  localparam int SRCR_B_HALT_MSG = 6;
  localparam int SRCR_B_PROTO_ST = 7;
  localparam int SRCR_B_MEM_ST = 9;
  localparam int SRCR_B_ST_CLEAR = 10;
  localparam int SRCR_B_RT_ONLINE = 11;
  // Time tag resolution code that selects software stepping
  localparam logic [2:0] SRCR_TT_SW_STEP = 3'h6;
  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRCR_MODE_BC = 2'h0,
    SRCR_MODE_RT = 2'h1,
    SRCR_MODE_MT = 2'h2
  } srcr_mode_t;
  // Auto online restore state machine
  typedef enum logic [1:0] {
    SRCR_ST_IDLE = 2'h0,
    SRCR_ST_OFFLINE = 2'h1,
    SRCR_ST_TESTING = 2'h2
  } srcr_state_t;
endpackage : srcr_pkg

// File: core/srcr_strobe.sv
// Write decoder that turns one command word into single cycle strobes
`timescale 1ns/100ps
module srcr_strobe #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] strobe
);
  typedef struct packed {
    logic [WIDTH-1:0] strobe;
  } srcr_sb_t;
  srcr_sb_t s_q;
  srcr_sb_t s_d;

  // ----------------------------------------------------------------
  // One pulse per written one, reserved bits masked
  // ----------------------------------------------------------------
  always_comb begin
    s_d.strobe = '0;
    if (wr_en) begin
      s_d.strobe = wr_data & ~WIDTH'(srcr_pkg::SRCR_RSVD_MASK);
    end
  end

  // Strobe register, no command state kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign strobe = s_q.strobe;
endmodule // srcr_strobe

// File: core/srcr_cmd_reg.sv
// Shared address block: pointer read and one shot command write
`timescale 1ns/100ps
module srcr_cmd_reg #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [WIDTH-1:0] host_wdata,
  output logic [WIDTH-1:0] host_rdata,
  input wire logic [1:0] op_mode,
  input wire logic enhanced_bc,
  input wire logic [2:0] timetag_res,
  input wire logic offline_after_selftest,
  input wire logic selftest_mc_rx,
  input wire logic selftest_done,
  input wire logic stack_ptr_load,
  input wire logic [WIDTH-1:0] stack_ptr_val,
  input wire logic [WIDTH-1:0] instr_list_ptr,
  input wire logic irq_level_mode,
  input wire logic irq_event,
  output logic irq_n,
  output logic rt_offline,
  output logic rt_online_restore,
  output logic selftest_result_clear,
  output logic memory_selftest_go,
  output logic protocol_selftest_go,
  output logic halt_at_message_end,
  output logic monitor_stop,
  output logic halt_at_frame_end,
  output logic timetag_step,
  output logic timetag_zero,
  output logic irq_status_clear,
  output logic controller_monitor_launch,
  output logic soft_reinit
);
  typedef struct packed {
    logic [WIDTH-1:0] stack_ptr;
    logic [WIDTH-1:0] rdata;
    srcr_pkg::srcr_state_t st;
    logic irq_pend;
  } srcr_cr_t;
  srcr_cr_t r_q;
  srcr_cr_t r_d;
  logic [WIDTH-1:0] strobe;
  logic is_bc;
  logic is_mt;
  logic is_rt;
  logic sel;

  // ----------------------------------------------------------------
  // Command write decode
  // ----------------------------------------------------------------
  assign sel = (host_addr == srcr_pkg::SRCR_ADDR_CMD);

  // Write only command path, reserved bits dropped
  srcr_strobe #(
    .WIDTH(WIDTH)
  ) u_strobe (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(host_wr && sel),
    .wr_data(host_wdata),
    .strobe(strobe)
  );

  assign is_bc = (op_mode == 2'(srcr_pkg::SRCR_MODE_BC));
  assign is_mt = (op_mode == 2'(srcr_pkg::SRCR_MODE_MT));
  assign is_rt = (op_mode == 2'(srcr_pkg::SRCR_MODE_RT));

  // ----------------------------------------------------------------
  // Strobes routed to their targets
  // ----------------------------------------------------------------
  assign selftest_result_clear = strobe[srcr_pkg::SRCR_B_ST_CLEAR];
  assign memory_selftest_go = strobe[srcr_pkg::SRCR_B_MEM_ST];
  assign protocol_selftest_go = strobe[srcr_pkg::SRCR_B_PROTO_ST];
  assign halt_at_message_end = strobe[srcr_pkg::SRCR_B_HALT_MSG] && is_bc;
  assign monitor_stop = strobe[srcr_pkg::SRCR_B_HALT_MSG] && is_mt;
  assign halt_at_frame_end = strobe[srcr_pkg::SRCR_B_HALT_FRAME] && is_bc;
  assign timetag_step = strobe[srcr_pkg::SRCR_B_TT_STEP]
    && (timetag_res == srcr_pkg::SRCR_TT_SW_STEP);
  assign timetag_zero = strobe[srcr_pkg::SRCR_B_TT_ZERO];
  assign irq_status_clear = strobe[srcr_pkg::SRCR_B_IRQ_CLEAR];
  assign controller_monitor_launch = strobe[srcr_pkg::SRCR_B_LAUNCH]
    && (is_bc || is_mt);
  assign soft_reinit = strobe[srcr_pkg::SRCR_B_SOFT_REINIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    // Stack pointer follows the engine, cleared by soft reset
    if (soft_reinit) begin
      r_d.stack_ptr = WIDTH'(srcr_pkg::SRCR_PTR_RESET);
    end else if (stack_ptr_load) begin
      r_d.stack_ptr = stack_ptr_val;
    end
    // Read data captured on a read of the shared address
    if (host_rd && sel) begin
      if (is_bc && enhanced_bc) begin
        r_d.rdata = instr_list_ptr;
      end else begin
        r_d.rdata = r_q.stack_ptr;
      end
    end
    // Offline and restore sequence
    case (r_q.st)
      srcr_pkg::SRCR_ST_IDLE: begin
        if (is_rt && offline_after_selftest && selftest_mc_rx) begin
          r_d.st = srcr_pkg::SRCR_ST_OFFLINE;
        end
      end
      srcr_pkg::SRCR_ST_OFFLINE: begin
        if (strobe[srcr_pkg::SRCR_B_RT_ONLINE]) begin
          r_d.st = srcr_pkg::SRCR_ST_IDLE;
        end else if (protocol_selftest_go) begin
          r_d.st = srcr_pkg::SRCR_ST_TESTING;
        end
      end
      srcr_pkg::SRCR_ST_TESTING: begin
        if (selftest_done || strobe[srcr_pkg::SRCR_B_RT_ONLINE]) begin
          r_d.st = srcr_pkg::SRCR_ST_IDLE;
        end
      end
      default: begin
        r_d.st = srcr_pkg::SRCR_ST_IDLE;
      end
    endcase
    if (soft_reinit) begin
      r_d.st = srcr_pkg::SRCR_ST_IDLE;
    end
    // Level interrupt held until status cleared or soft reinit; new event wins
    if (irq_event) begin
      r_d.irq_pend = 1'b1;
    end else if (irq_status_clear || soft_reinit) begin
      r_d.irq_pend = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_q.stack_ptr <= WIDTH'(srcr_pkg::SRCR_PTR_RESET);
      r_q.rdata <= WIDTH'(srcr_pkg::SRCR_PTR_RESET);
      r_q.st <= srcr_pkg::SRCR_ST_IDLE;
      r_q.irq_pend <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_rdata = r_q.rdata;
  assign rt_offline = (r_q.st != srcr_pkg::SRCR_ST_IDLE);
  // Online strobe when leaving offline state
  assign rt_online_restore = rt_offline && (r_d.st == srcr_pkg::SRCR_ST_IDLE);
  // Level mode holds low; pulse mode left to the interrupt block
  assign irq_n = !(irq_level_mode && r_q.irq_pend);
endmodule // srcr_cmd_reg

// File: dv/srcr_sva.sv
// Assertion checker for the start/reset command block
`timescale 1ns/100ps
module srcr_sva #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] host_addr,
  input wire logic host_wr,
  input wire logic [WIDTH-1:0] host_wdata,
  input wire logic [1:0] op_mode,
  input wire logic [2:0] timetag_res,
  input wire logic soft_reinit,
  input wire logic irq_status_clear,
  input wire logic timetag_step,
  input wire logic controller_monitor_launch
);
  logic wr3;
  // Write taken at the shared address
  assign wr3 = host_wr && host_addr == srcr_pkg::SRCR_ADDR_CMD;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_soft_go: assert property (wr3 && host_wdata[0] |=> soft_reinit)
    else $error("reinit strobe missing");
  chk_zero_quiet: assert property (wr3 && !host_wdata[0] |=> !soft_reinit)
    else $error("reinit strobe on zero bit");
  chk_clear_pulse: assert property (wr3 && host_wdata[2] |=> irq_status_clear
    ##1 (!irq_status_clear || $past(wr3 && host_wdata[2])))
    else $error("status clear not one cycle");
  chk_step_go: assert property (wr3 && host_wdata[4] && timetag_res == 3'h6 |=> timetag_step)
    else $error("time tag step missing");
  chk_step_gate: assert property (timetag_step |-> timetag_res == 3'h6 && $past(wr3))
    else $error("time tag step without cause");
  chk_launch_go: assert property (wr3 && host_wdata[1] && (op_mode == 2'h0 || op_mode == 2'h2)
    |=> controller_monitor_launch)
    else $error("launch strobe missing");
  chk_launch_rt: assert property (controller_monitor_launch |-> op_mode == 2'h0 || op_mode == 2'h2)
    else $error("launch strobe in RT mode");
  chk_write_only: assert property (soft_reinit |-> $past(wr3) && $past(host_wdata[0]))
    else $error("reinit strobe without write");
endmodule // srcr_sva
bind srcr_cmd_reg srcr_sva #(.WIDTH(WIDTH)) srcr_sva_inst (.*);

// File: dv/srcr_host.sv
// Host processor model driving the parallel host bus
`timescale 1ns/100ps
module srcr_host (
  input wire logic mclk,
  output logic [15:0] host_addr,
  output logic host_rd,
  output logic host_wr,
  output logic [15:0] host_wdata
);
  // Bus idle at time zero
  initial begin
    host_addr = 16'hfffc;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 16'h0000;
  end
  // One access entered after an edge, held to the taking edge
  task automatic xfer(input logic wr, input logic [15:0] d);
    host_addr = srcr_pkg::SRCR_ADDR_CMD;
    host_wdata = d & ~srcr_pkg::SRCR_RSVD_MASK;
    host_wr = wr;
    host_rd = !wr;
    @(posedge mclk);
    #1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask
endmodule // srcr_host

// File: dv/start_reset_command_register_tb.sv
// Self-checking bench for the start/reset command block
`timescale 1ns/100ps
module start_reset_command_register_tb;
  logic mclk, rst_n, enhanced_bc, offline_after_selftest, selftest_mc_rx, selftest_done;
  logic stack_ptr_load, irq_level_mode, irq_event, irq_n, rt_offline, host_rd, host_wr;
  logic rd_seen = 1'b0;
  logic [1:0] op_mode;
  logic [2:0] timetag_res;
  logic [11:0] s;
  logic [15:0] host_addr, host_wdata, host_rdata, stack_ptr_val, instr_list_ptr;
  logic [11:0] sq[$];
  logic [15:0] wq[$];
  int fail_count = 0;
  int checks = 0;
  srcr_host srcr_host_inst (.*);
  srcr_cmd_reg srcr_cmd_reg_inst (.*, .rt_online_restore(s[11]), .selftest_result_clear(s[10]),
    .memory_selftest_go(s[9]), .protocol_selftest_go(s[8]), .halt_at_message_end(s[7]),
    .monitor_stop(s[6]), .halt_at_frame_end(s[5]), .timetag_step(s[4]), .timetag_zero(s[3]),
    .irq_status_clear(s[2]), .controller_monitor_launch(s[1]), .soft_reinit(s[0]));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp_s(input logic [11:0] g, input logic [11:0] x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("Error at %0t: strobes %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmp_w(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("Error at %0t: value %h expected %h", $time, g, x);
    end
  endtask
  // Write a command and note the strobes it should raise
  task automatic cmd(input logic [15:0] d, input logic [1:0] m, input logic [2:0] r);
    logic bc, mt;
    logic [11:0] e;
    @(posedge mclk);
    #1;
    op_mode = m;
    timetag_res = r;
    bc = m == srcr_pkg::SRCR_MODE_BC;
    mt = m == srcr_pkg::SRCR_MODE_MT;
    e = {1'b0, d[10], d[9], d[7], d[6] && bc, d[6] && mt, d[5] && bc,
      d[4] && r == srcr_pkg::SRCR_TT_SW_STEP, d[3], d[2], d[1] && (bc || mt), d[0]};
    if (e != 12'h000) sq.push_back(e);
    srcr_host_inst.xfer(1'b1, d);
  endtask
  task automatic rdchk(input logic [15:0] x);
    @(posedge mclk);
    #1;
    wq.push_back(x);
    srcr_host_inst.xfer(1'b0, 16'h0000);
  endtask
  task automatic pulse(ref logic p);
    @(posedge mclk);
    #1;
    p = 1'b1;
    @(posedge mclk);
    #1;
    p = 1'b0;
  endtask
  // Match each appearing result with the oldest note
  always @(posedge mclk) begin
    if (s !== 12'h000) cmp_s(s, sq.size() > 0 ? sq.pop_front() : 12'hfff);
    if (rd_seen === 1'b1) cmp_w(host_rdata, wq.pop_front());
    rd_seen <= host_rd;
  end
  // Cut a hung run short
  initial begin
    repeat (5000) @(posedge mclk);
    cmp_w(16'h0001, 16'h0000);
    summarize();
  end
  // Main sequence
  initial begin
    {rst_n, enhanced_bc, selftest_mc_rx, selftest_done, stack_ptr_load} = '0;
    {irq_event, irq_level_mode, op_mode, timetag_res, stack_ptr_val, instr_list_ptr} = '0;
    offline_after_selftest = 1'b1;
    void'($urandom(679));
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    rdchk(16'h0000);
    for (int i = 0; i < 4; i++) begin
      stack_ptr_val = 16'($urandom);
      instr_list_ptr = 16'($urandom);
      enhanced_bc = (i == 3);
      op_mode = (i == 3) ? 2'h0 : 2'(i);
      pulse(stack_ptr_load);
      rdchk(enhanced_bc ? instr_list_ptr : stack_ptr_val);
    end
    enhanced_bc = 1'b0;
    for (int i = 0; i < 40; i++) begin
      cmd(16'($urandom), 2'($urandom_range(2)), ($urandom_range(1) != 0) ? 3'h6 : 3'($urandom));
    end
    cmd(16'h0001, 2'h0, 3'h0);
    rdchk(16'h0000);
    op_mode = 2'h1;
    pulse(selftest_mc_rx);
    cmd(16'h0080, 2'h1, 3'h0);
    cmp_w(16'(rt_offline), 16'h0001);
    sq.push_back(12'h800);
    pulse(selftest_done);
    repeat (2) @(posedge mclk);
    #1 cmp_w(16'(rt_offline), 16'h0000);
    pulse(selftest_mc_rx);
    sq.push_back(12'h800);
    cmd(16'h0800, 2'h1, 3'h0);
    irq_level_mode = 1'b1;
    pulse(irq_event);
    repeat (3) @(posedge mclk);
    #1 cmp_w(16'(irq_n), 16'h0000);
    cmd(16'h0004, 2'h1, 3'h0);
    repeat (2) @(posedge mclk);
    #1 cmp_w(16'(irq_n), 16'h0001);
    cmp_w(16'(rt_offline), 16'h0000);
    cmp_w(16'(sq.size() + wq.size()), 16'h0000);
    summarize();
  end
endmodule // start_reset_command_register_tb
